// [src/port_power_attach.sv]
// one port: high-voltage path supervision, vconn, discharge and dfp attach detection
module port_power_attach #(
	parameter int DISCHARGE_CYC = port_power_pkg::DISCHARGE_TIME_LIMIT_CYC,
	parameter int DEGLITCH_CYC = port_power_pkg::CLAMP_DEGLITCH_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	// firmware configuration
	input wire logic dfp_mode,
	input wire logic port_is_source,
	input wire logic hv_enable,
	input wire logic hv_reenable,
	input wire logic [1:0] clamp_level_cfg,
	input wire logic [1:0] adv_level_cfg,
	input wire logic ext_ctrl_cfg,
	input wire logic ext_enable,
	input wire logic vconn_enable,
	input wire logic discharge_0v_req,
	// analog comparators and cc classifiers (asynchronous)
	input wire logic [1:0] cc1_class,
	input wire logic [1:0] cc2_class,
	input wire logic clamp_active,
	input wire logic ocp_trip,
	input wire logic vbus_over_ovp,
	input wire logic vbus_under_uvp,
	input wire logic reverse_current,
	input wire logic vconn_input_good,
	input wire logic vbus_above_safe5v,
	input wire logic vbus_above_safe0v,
	// controls and status
	output logic [1:0] clamp_current_level,
	output logic clamp_enable,
	output logic high_voltage_path,
	output logic hv_latched_off,
	output logic rev_comparator_mode,
	output logic rev_ideal_diode_mode,
	output logic external_path_control,
	output logic vconn_supply_switch,
	output logic vconn_to_cc1,
	output logic vconn_limit_en,
	output logic [1:0] cc_source_current,
	output logic [1:0] detach_threshold,
	output logic [1:0] cable_detect_threshold,
	output logic vbus_pulldown,
	output logic discharge_timeout,
	output logic vbus_source_req,
	output logic [5:0] attach_state,
	output logic monitor_cc1,
	output logic monitor_cc2
);
	import port_power_pkg::*;

	// refuse timer lengths the counters cannot serve
	if (DEGLITCH_CYC < 1 || DISCHARGE_CYC < 1 || VCONN_LIMIT_MA != 600)
	begin : g_bad_param
		$error("port_power_attach: bad timing parameter");
	end

	// true when the pin classification equals the code
	function automatic logic is_class(input logic [1:0] cls, input logic [1:0] code);
		is_class = (cls == code);
	endfunction : is_class

	// two-flop synchronisers for all asynchronous inputs
	localparam int SW = 12;
	logic [SW-1:0] raw_in;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	assign raw_in = {cc1_class, cc2_class, clamp_active, ocp_trip, vbus_over_ovp,
		vbus_under_uvp, reverse_current, vconn_input_good, vbus_above_safe5v,
		vbus_above_safe0v};

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	wire logic [1:0] cc1_s = sync2_q[11:10];
	wire logic [1:0] cc2_s = sync2_q[9:8];
	wire logic clamp_s = sync2_q[7];
	wire logic ocp_s = sync2_q[6];
	wire logic ovp_s = sync2_q[5];
	wire logic uvp_s = sync2_q[4];
	wire logic rev_s = sync2_q[3];
	wire logic vin_good_s = sync2_q[2];
	wire logic above5_s = sync2_q[1];
	wire logic above0_s = sync2_q[0];

	// per-pin classification, same decode for both pins
	wire logic cc1_rd = is_class(cc1_s, CC_RD);
	wire logic cc1_ra = is_class(cc1_s, CC_RA);
	wire logic cc1_open = is_class(cc1_s, CC_OPEN);
	wire logic cc2_rd = is_class(cc2_s, CC_RD);
	wire logic cc2_ra = is_class(cc2_s, CC_RA);
	wire logic cc2_open = is_class(cc2_s, CC_OPEN);

	// attach state machine
	attach_state_type state_q;
	attach_state_type state_d;
	attach_state_type fresh;
	logic orient_q; // 1: cc1 holds the rd (or ra when cable only)
	logic orient_d;
	logic fresh_orient;

	always_comb
	begin
		fresh = ST_UNATTACHED;
		fresh_orient = 1'b0;
		if (cc1_rd && cc2_rd)
			fresh = ST_DEBUG_ACC;
		else if (cc1_ra && cc2_ra)
			fresh = ST_AUDIO_ACC;
		else if ((cc1_ra && cc2_rd) || (cc1_rd && cc2_ra))
		begin
			fresh = ST_CABLE_UFP;
			fresh_orient = cc1_rd;
		end
		else if ((cc1_rd && cc2_open) || (cc1_open && cc2_rd))
		begin
			fresh = ST_UFP;
			fresh_orient = cc1_rd;
		end
		else if ((cc1_ra && cc2_open) || (cc1_open && cc2_ra))
		begin
			fresh = ST_CABLE_ONLY;
			fresh_orient = cc1_ra;
		end
	end

	wire logic mon_rd_gone = orient_q ? !cc1_rd : !cc2_rd;
	wire logic mon_ra_gone = orient_q ? !cc1_ra : !cc2_ra;
	wire logic open_pin_rd = orient_q ? cc2_rd : cc1_rd;

	always_comb
	begin
		state_d = state_q;
		orient_d = orient_q;
		case (state_q)
			ST_UNATTACHED:
			begin
				state_d = fresh;
				orient_d = fresh_orient;
			end
			ST_UFP:
				if (mon_rd_gone)
					state_d = ST_UNATTACHED;
			ST_CABLE_ONLY:
				if (open_pin_rd)
				begin
					state_d = ST_CABLE_UFP;
					orient_d = !orient_q;
				end
				else if (mon_ra_gone)
					state_d = ST_UNATTACHED;
			ST_CABLE_UFP:
				if (mon_rd_gone)
					state_d = ST_UNATTACHED;
			ST_DEBUG_ACC:
				if (!(cc1_rd && cc2_rd))
					state_d = ST_UNATTACHED;
			ST_AUDIO_ACC:
				if (!(cc1_ra && cc2_ra))
					state_d = ST_UNATTACHED;
			default:
				state_d = ST_UNATTACHED;
		endcase
		if (!dfp_mode)
			state_d = ST_UNATTACHED;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_UNATTACHED;
			orient_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			orient_q <= orient_d;
		end
	end

	// power decisions from attach state
	wire logic sources_vbus = (state_q == ST_UFP) || (state_q == ST_CABLE_UFP);
	wire logic vconn_wanted = (state_q == ST_CABLE_UFP) && vconn_enable;
	wire logic mon1 = (state_q == ST_UNATTACHED) || (state_q == ST_DEBUG_ACC)
		|| (state_q == ST_AUDIO_ACC) || (state_q == ST_CABLE_ONLY)
		|| (state_q == ST_UFP && orient_q) || (state_q == ST_CABLE_UFP && orient_q);
	wire logic mon2 = (state_q == ST_UNATTACHED) || (state_q == ST_DEBUG_ACC)
		|| (state_q == ST_AUDIO_ACC) || (state_q == ST_CABLE_ONLY)
		|| (state_q == ST_UFP && !orient_q) || (state_q == ST_CABLE_UFP && !orient_q);

	// clamp deglitch and latch-off
	logic [TIMER_W-1:0] clamp_cnt_q;
	logic latched_q;
	wire logic clamp_on = port_is_source;
	wire logic clamp_expired = clamp_on && clamp_s
		&& (clamp_cnt_q >= TIMER_W'(DEGLITCH_CYC));
	wire logic latch_set = clamp_expired || ocp_s;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			clamp_cnt_q <= '0;
		else if (clamp_on && clamp_s && !clamp_expired)
			clamp_cnt_q <= clamp_cnt_q + TIMER_W'(1);
		else if (!(clamp_on && clamp_s))
			clamp_cnt_q <= '0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			latched_q <= 1'b0;
		else if (latch_set)
			latched_q <= 1'b1;
		else if (hv_reenable)
			latched_q <= 1'b0;
	end

	wire logic volt_fault = ovp_s || uvp_s;
	wire logic hv_on_d = hv_enable && !latched_q && !latch_set && !volt_fault
		&& !rev_s;
	wire logic ext_on_d = ext_ctrl_cfg && ext_enable && !volt_fault;

	// vconn switch: closes only with good input, then holds
	logic vconn_q;
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			vconn_q <= 1'b0;
		else if (!vconn_wanted)
			vconn_q <= 1'b0;
		else if (!vconn_q && vin_good_s)
			vconn_q <= 1'b1;
	end

	// vsafe0v discharge with time limit
	logic dis0_q;
	logic [TIMER_W-1:0] dis_cnt_q;
	logic dis_to_q;
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			dis0_q <= 1'b0;
			dis_cnt_q <= '0;
			dis_to_q <= 1'b0;
		end
		else
		begin
			if (discharge_0v_req && above0_s && !hv_on_d)
				dis0_q <= 1'b1;
			else if (!above0_s || !discharge_0v_req)
				dis0_q <= 1'b0;
			if (!dis0_q)
				dis_cnt_q <= '0;
			else if (dis_cnt_q < TIMER_W'(DISCHARGE_CYC))
				dis_cnt_q <= dis_cnt_q + TIMER_W'(1);
			if (!discharge_0v_req)
				dis_to_q <= 1'b0;
			else if (dis0_q && dis_cnt_q >= TIMER_W'(DISCHARGE_CYC))
				dis_to_q <= 1'b1;
		end
	end

	wire logic pulldown_d = (!hv_on_d && above5_s) || dis0_q;

	// registered outputs
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			high_voltage_path <= 1'b0;
			external_path_control <= 1'b0;
			vbus_pulldown <= 1'b0;
			clamp_current_level <= 2'h0;
			cc_source_current <= ADV_DEFAULT;
		end
		else
		begin
			high_voltage_path <= hv_on_d;
			external_path_control <= ext_on_d;
			vbus_pulldown <= pulldown_d;
			clamp_current_level <= clamp_level_cfg;
			cc_source_current <= (adv_level_cfg == ADV_3A) ? ADV_3A
				: (adv_level_cfg == ADV_1P5A) ? ADV_1P5A : ADV_DEFAULT;
		end
	end

	assign clamp_enable = clamp_on;
	assign hv_latched_off = latched_q;
	assign rev_comparator_mode = port_is_source;
	assign rev_ideal_diode_mode = !port_is_source;
	assign vconn_supply_switch = vconn_q;
	assign vconn_to_cc1 = !orient_q;
	assign vconn_limit_en = vconn_q;
	assign detach_threshold = cc_source_current;
	assign cable_detect_threshold = cc_source_current;
	assign discharge_timeout = dis_to_q;
	assign vbus_source_req = sources_vbus;
	assign attach_state = state_q;
	assign monitor_cc1 = mon1;
	assign monitor_cc2 = mon2;
endmodule : port_power_attach

// [src/port_power_pkg.sv]
// constants and types for the type-c port power and attach control block
// Functional notes
// - clamp only while sourcing, firmware-chosen level
// - clamp beyond deglitch latches path off
// - trip-level forward drop latches path off
// - overvoltage or undervoltage disables high-voltage path
// - comparator mode sourcing, ideal diode sinking
// - external control active high, dropped on overvoltage or undervoltage
// - external path ignores overcurrent and thermal faults
// - vconn switch limited to 600 mA ceiling
// - vconn closes only with input good
// - closed vconn ignores later input drop
// - pull-down on while disabled above vsafe5v
// - vsafe0v pull-down until reached, timeout flagged at limit but pull-down held
// - both open: monitor, no vbus, no vconn
// - one rd: vbus only, watch rd pin
// - one ra: no power, watch both pins
// - ra plus rd: vbus, vconn on ra
// - rd-rd debug, ra-ra audio, detach either
// - advertise default, 1.5 A or 3 A
// - active cable below cable-detect threshold
// - detach above detach threshold for level
// - identical detection logic on every cc pin
package port_power_pkg;
	// cc pin classification codes
	localparam logic [1:0] CC_OPEN = 2'h0;
	localparam logic [1:0] CC_RA = 2'h1;
	localparam logic [1:0] CC_RD = 2'h2;
	// advertised current level codes
	localparam logic [1:0] ADV_DEFAULT = 2'h0;
	localparam logic [1:0] ADV_1P5A = 2'h1;
	localparam logic [1:0] ADV_3A = 2'h2;
	// vconn switch current ceiling
	localparam int VCONN_LIMIT_MA = 600;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int CLAMP_DEGLITCH_NS = 10000;
	localparam int CLAMP_DEGLITCH_CYC = (CLAMP_DEGLITCH_NS * CLK_MHZ) / 1000;
	localparam int DISCHARGE_TIME_LIMIT_US = 650000;
	localparam int DISCHARGE_TIME_LIMIT_CYC = DISCHARGE_TIME_LIMIT_US * CLK_MHZ;
	localparam int TIMER_W = 32;

	typedef enum logic [5:0] {
		ST_UNATTACHED = 6'h01,
		ST_UFP = 6'h02,
		ST_CABLE_ONLY = 6'h04,
		ST_CABLE_UFP = 6'h08,
		ST_DEBUG_ACC = 6'h10,
		ST_AUDIO_ACC = 6'h20
	} attach_state_type;
endpackage : port_power_pkg

// [dv/cc_partner_model.sv]
// far-side partner presenting cc terminations to the port
module cc_partner_model (
	input wire logic mclk,
	input wire logic [3:0] plug_code,
	output logic [1:0] cc1_class,
	output logic [1:0] cc2_class
);
	timeunit 1ns;
	timeprecision 100ps;
	// termination settles one edge after the plug changes
	always_ff @(posedge mclk)
	begin
		cc1_class <= plug_code[1:0];
		cc2_class <= plug_code[3:2];
	end
endmodule : cc_partner_model

// [dv/port_power_attach_chk.sv]
// assertions on the port power and attach control ports
module port_power_attach_chk
	import port_power_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic port_is_source,
	input wire logic vbus_over_ovp,
	input wire logic vbus_under_uvp,
	input wire logic clamp_enable,
	input wire logic high_voltage_path,
	input wire logic hv_latched_off,
	input wire logic rev_comparator_mode,
	input wire logic rev_ideal_diode_mode,
	input wire logic external_path_control,
	input wire logic vconn_supply_switch,
	input wire logic vconn_limit_en,
	input wire logic [1:0] cc_source_current,
	input wire logic [1:0] detach_threshold,
	input wire logic [1:0] cable_detect_threshold,
	input wire logic vbus_pulldown,
	input wire logic vbus_source_req,
	input wire logic [5:0] attach_state,
	input wire logic monitor_cc1,
	input wire logic monitor_cc2
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	AST_CLAMP_SRC: assert property (clamp_enable == port_is_source)
		else $error("clamp enable not tied to source role");
	AST_REV_MODE: assert property (rev_comparator_mode == port_is_source
		&& rev_ideal_diode_mode == !port_is_source) else $error("reverse mode wrong");
	AST_OV_PATH: assert property ((vbus_over_ovp || vbus_under_uvp)[*3] |=>
		!high_voltage_path) else $error("path on during voltage fault");
	AST_OV_EXT: assert property ((vbus_over_ovp || vbus_under_uvp)[*3] |=>
		!external_path_control) else $error("external path on during voltage fault");
	AST_LATCH_OFF: assert property (hv_latched_off[*2] |-> !high_voltage_path)
		else $error("path on while latched");
	AST_VCONN_LIM: assert property (vconn_limit_en == vconn_supply_switch)
		else $error("vconn limit not with switch");
	AST_ONE_HOT: assert property ($onehot(attach_state))
		else $error("attach state not one-hot");
	AST_SRC_REQ: assert property (vbus_source_req ==
		(attach_state inside {ST_UFP, ST_CABLE_UFP})) else $error("vbus request wrong");
	AST_UNATT: assert property ((attach_state == ST_UNATTACHED) [*2] |->
		monitor_cc1 && monitor_cc2 && !vconn_supply_switch) else $error("unattached wrong");
	AST_UFP_MON: assert property (attach_state == ST_UFP |-> monitor_cc1 ^ monitor_cc2)
		else $error("ufp must watch one pin");
	AST_ADV_THR: assert property (detach_threshold == cc_source_current
		&& cable_detect_threshold == cc_source_current) else $error("threshold level wrong");
	COV_CABLE_UFP: cover property (attach_state == ST_CABLE_UFP && vconn_supply_switch);
	COV_LATCH: cover property ($rose(hv_latched_off));
	COV_PULLDOWN: cover property ($rose(vbus_pulldown));
endmodule : port_power_attach_chk

bind port_power_attach port_power_attach_chk u_chk (.*);

// [dv/port_power_attach_tb_top.sv]
// self-checking bench for the port power and attach control block
module port_power_attach_tb_top
	import port_power_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEG = 4;
	localparam int DIS = 50;
	logic mclk = 1'h0, rst_n = 1'h0, dfp_mode = 1'h1, port_is_source = 1'h1;
	logic hv_enable = 1'h0, hv_reenable = 1'h0, ext_ctrl_cfg = 1'h1, ext_enable = 1'h1;
	logic vconn_enable = 1'h1, discharge_0v_req = 1'h0, clamp_active = 1'h0, ocp_trip = 1'h0;
	logic vbus_over_ovp = 1'h0, vbus_under_uvp = 1'h0, reverse_current = 1'h0;
	logic vconn_input_good = 1'h1, vbus_above_safe5v = 1'h0, vbus_above_safe0v = 1'h0;
	logic [1:0] clamp_level_cfg = 2'h0, adv_level_cfg = 2'h0, cc1_class, cc2_class;
	logic [3:0] plug_code = 4'h0;
	logic [1:0] clamp_current_level, cc_source_current, detach_threshold, cable_detect_threshold;
	logic clamp_enable, high_voltage_path, hv_latched_off, rev_comparator_mode;
	logic rev_ideal_diode_mode, external_path_control, vconn_supply_switch, vconn_to_cc1;
	logic vconn_limit_en, vbus_pulldown, discharge_timeout, vbus_source_req;
	logic monitor_cc1, monitor_cc2;
	logic [5:0] attach_state;
	int n_fail = 0;
	int checks_done = 0;
	int seed = 32'h2030a36b;

	always #2.5 mclk = ~mclk;

	cc_partner_model u_partner (.*);
	port_power_attach #(.DISCHARGE_CYC(DIS), .DEGLITCH_CYC(DEG)) u_dut (.*);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt

	// cc pair to expected one-hot attach state
	function automatic int exp_state(input int a, input int b);
		if (a + b == 0)
			return 1;
		if (a == b)
			return (a == 2) ? 16 : 32;
		if (a * b == 0)
			return (a + b == 2) ? 2 : 4;
		return 8;
	endfunction : exp_state

	task automatic rearm;
		@(posedge mclk);
		hv_reenable <= 1'h1;
		@(posedge mclk);
		hv_reenable <= 1'h0;
		wt(4);
		chk(8'({hv_latched_off, high_voltage_path}), 8'h01);
	endtask : rearm

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	initial
	begin
		int a, b, s, i;
		logic p;
		logic [31:0] v;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		wt(3);
		chk(8'(attach_state), 8'h01);
		for (a = 0; a < 3; a++)
			for (b = 0; b < 3; b++)
			begin
				// unplug first so every attach starts from the unattached state
				@(posedge mclk);
				plug_code <= 4'h0;
				wt(7);
				chk(8'(attach_state), 8'h01);
				@(posedge mclk);
				plug_code <= 4'(b * 4 + a);
				wt(7);
				s = exp_state(a, b);
				p = (s == 2 || s == 8);
				chk(8'(attach_state), 8'(s));
				chk(8'({vbus_source_req, vconn_supply_switch}), 8'({p, s == 8}));
				chk(8'({monitor_cc1, monitor_cc2}), 8'({!(p && b == 2), !(p && a == 2)}));
				if (s == 8)
					chk(8'(vconn_to_cc1), 8'(a == 1));
			end
		for (i = 0; i < 4; i++)
		begin
			@(posedge mclk);
			v = $random(seed);
			adv_level_cfg <= 2'(i);
			clamp_level_cfg <= v[1:0];
			wt(3);
			s = (i == 3) ? 0 : i;
			chk(8'(cc_source_current), 8'(s));
			chk(8'(clamp_current_level), 8'(v[1:0]));
			chk(8'({detach_threshold, cable_detect_threshold}), 8'({2'(s), 2'(s)}));
		end
		@(posedge mclk);
		plug_code <= 4'h2;
		hv_enable <= 1'h1;
		wt(8);
		chk(8'(high_voltage_path), 8'h01);
		@(posedge mclk);
		clamp_active <= 1'h1;
		wt(DEG + 6);
		chk(8'({hv_latched_off, high_voltage_path}), 8'h02);
		@(posedge mclk);
		clamp_active <= 1'h0;
		wt(3);
		rearm();
		@(posedge mclk);
		ocp_trip <= 1'h1;
		repeat (3) @(posedge mclk);
		ocp_trip <= 1'h0;
		wt(3);
		chk(8'({hv_latched_off, external_path_control}), 8'h03);
		rearm();
		for (i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			{vbus_over_ovp, vbus_under_uvp, reverse_current} <= 3'(4 >> i);
			wt(4);
			chk(8'({high_voltage_path, external_path_control}), 8'(i == 2));
			@(posedge mclk);
			{vbus_over_ovp, vbus_under_uvp, reverse_current} <= 3'h0;
			wt(4);
			chk(8'({high_voltage_path, hv_latched_off}), 8'h02);
		end
		// sinking: no clamp, ideal diode mode, external control unconfigured
		@(posedge mclk);
		port_is_source <= 1'h0;
		ext_ctrl_cfg <= 1'h0;
		clamp_active <= 1'h1;
		wt(DEG + 6);
		chk(8'({hv_latched_off, high_voltage_path, clamp_enable}), 8'h02);
		chk(8'({external_path_control, rev_ideal_diode_mode}), 8'h01);
		@(posedge mclk);
		clamp_active <= 1'h0;
		wt(3);
		@(posedge mclk);
		port_is_source <= 1'h1;
		ext_ctrl_cfg <= 1'h1;
		wt(4);
		chk(8'({rev_comparator_mode, rev_ideal_diode_mode, clamp_enable}), 8'h05);
		chk(8'({external_path_control, hv_latched_off}), 8'h02);
		// cable alone first, then the sink appears on the open pin
		@(posedge mclk);
		plug_code <= 4'h1;
		wt(7);
		chk(8'({attach_state, vbus_source_req, vconn_supply_switch}), 8'h10);
		@(posedge mclk);
		plug_code <= 4'h9;
		vconn_input_good <= 1'h0;
		wt(7);
		chk(8'(vconn_supply_switch), 8'h00);
		@(posedge mclk);
		vconn_input_good <= 1'h1;
		wt(5);
		chk(8'({vconn_supply_switch, vconn_limit_en, vconn_to_cc1}), 8'h07);
		@(posedge mclk);
		vconn_input_good <= 1'h0;
		wt(5);
		chk(8'(vconn_supply_switch), 8'h01);
		@(posedge mclk);
		hv_enable <= 1'h0;
		vbus_above_safe5v <= 1'h1;
		wt(5);
		chk(8'(vbus_pulldown), 8'h01);
		@(posedge mclk);
		vbus_above_safe5v <= 1'h0;
		discharge_0v_req <= 1'h1;
		vbus_above_safe0v <= 1'h1;
		wt(5);
		chk(8'({vbus_pulldown, discharge_timeout}), 8'h02);
		wt(DIS + 2);
		chk(8'(discharge_timeout), 8'h01);
		@(posedge mclk);
		vbus_above_safe0v <= 1'h0;
		wt(5);
		chk(8'(vbus_pulldown), 8'h00);
		@(posedge mclk);
		discharge_0v_req <= 1'h0;
		dfp_mode <= 1'h0;
		wt(4);
		chk(8'(attach_state), 8'h01);
		end_sim();
	end

	initial
	begin
		#10000;
		n_fail++;
		end_sim();
	end
endmodule : port_power_attach_tb_top
